// ==== rtl/dbs_cfg.svh ====
/*
 Offsets, field positions and reset values for the device and bus status bank.
 Assumes it is included by bare name from rtl/ files.
*/
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH
// Register addresses on the serial register port
`define DBS_DEV_ADDR 7'h43
`define DBS_BUS_ADDR 7'h44
// Field positions of the device information status register
`define DBS_PRE_HI 7
`define DBS_PRE_LO 6
`define DBS_WDC_HI 3
`define DBS_WDC_LO 2
`define DBS_CMDF_BIT 1
`define DBS_FAIL_BIT 0
// Field positions of the bus communication status register
`define DBS_XF_HI 2
`define DBS_XF_LO 1
`define DBS_BUV_BIT 0
// Reset values
`define DBS_DEV_RST 8'h00
`define DBS_BUS_RST 8'h00
`endif

// ==== rtl/dbs_pkg.sv ====
/*
 Types shared by the device and bus status bank.
 Assumes dbs_cfg.svh is on the include path.
*/
package dbs_pkg;
  // Pre-restart state codes
  typedef enum logic [1:0] {
    DBS_PRE_CLEAR = 2'h0,
    DBS_PRE_FAIL = 2'h1,
    DBS_PRE_SLEEP = 2'h2,
    DBS_PRE_RSVD = 2'h3
  } dbs_pre_t;
  // Transceiver failure codes
  typedef enum logic [1:0] {
    DBS_XF_NONE = 2'h0,
    DBS_XF_THERM = 2'h1,
    DBS_XF_TXDOM = 2'h2,
    DBS_XF_BUSDOM = 2'h3
  } dbs_xf_t;
  // Events raised by the surrounding device logic, one-cycle pulses
  typedef struct packed {
    logic watchdog_failure_count;
    logic wd_ok;
    logic sev_ot;
    logic main_uv;
    logic sleep_nowake;
    logic failsafe_wake;
    logic sleep_entry;
    logic sleep_flags_set;
    logic bad_cmd;
    logic fail_out_on;
    logic xcv_therm;
    logic txd_dom;
    logic bus_dom;
  } dbs_evt_t;
  // Register write from the serial command decoder
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } dbs_wr_t;
endpackage : dbs_pkg

// ==== rtl/dbs_sync3.sv ====
/*
 Three-stage synchroniser for a level from outside the clock domain.
 A change is taken once the second and third stages agree.
*/
`timescale 1ns/1ps
module dbs_sync3 (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic async_i, // Asynchronous level
  output logic sync_o // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // Shift chain
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Accept only stable level
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync_o <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      sync_o <= s3_reg;
    end
  end
endmodule : dbs_sync3

// ==== rtl/dbs_wd_count.sv ====
/*
 Watchdog failure counter with freeze in configurations 2 and 4.
 Assumes fail and ok pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
module dbs_wd_count
  import dbs_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic watchdog_failure_count_i, // Trigger failure pulse
  input wire logic wd_ok_i, // Correct trigger pulse
  input wire logic freeze_cfg_i, // Configuration 2 or 4
  input wire logic one_fail_cfg_i, // Configuration 2: limit one
  input wire logic clr_i, // Host clear of the counter
  output logic [1:0] count_o, // Counter value
  output logic frozen_o // Counter held
);
  // Freeze after failure until correct trigger
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      frozen_o <= 1'b0;
    end else if (wd_ok_i) begin
      frozen_o <= 1'b0;
    end else if (watchdog_failure_count_i && freeze_cfg_i) begin
      frozen_o <= 1'b1;
    end
  end
  // Count failures, saturate below 11, self-clear on good trigger when not frozen
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      count_o <= 2'h0;
    end else if (watchdog_failure_count_i && !frozen_o) begin
      if (one_fail_cfg_i) begin
        count_o <= 2'h1;
      end else if (count_o != 2'h2) begin
        count_o <= count_o + 2'h1;
      end
    end else if ((wd_ok_i && !frozen_o) || clr_i) begin
      count_o <= 2'h0;
    end
  end
  // Counter range and freeze checks
  a_wdc_never_three: assert property (@(posedge clk_i) disable iff (!nrst_i)
    count_o != 2'h3) else $error("watchdog count reached 11");
  a_wdc_frozen_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    frozen_o && !wd_ok_i && !clr_i |=> $stable(count_o))
    else $error("frozen watchdog count changed");
endmodule : dbs_wd_count

// ==== rtl/dbs_status_regs.sv ====
/*
 Device information status and bus communication status registers.
 Assumes the serial decoder gives one-cycle write strobes on this clock; a write
 of 1 to a flag bit clears it. Restart is not a reset here: nrst_i is power-on
 or soft reset only.
*/
`timescale 1ns/1ps
`include "dbs_cfg.svh"
module dbs_status_regs
  import dbs_pkg::*;
(
  input wire logic clk_i, // 20 MHz system clock
  input wire logic nrst_i, // Power-on or soft reset, active low
  input dbs_evt_t evt_i, // Event pulses from device logic
  input dbs_wr_t wr_i, // Host write strobe
  input wire logic rd_i, // Host read strobe
  input wire logic [6:0] rd_addr_i, // Host read address
  input wire logic [1:0] dev_cfg_i, // Device configuration select, 0..3 = 1..4
  input wire logic xcv_mode_i, // Transceiver mode bit
  input wire logic bus_uv_pin_i, // Bus supply undervoltage comparator
  output logic [7:0] rd_data_o, // Read data
  output logic [7:0] dev_info_o, // Device register image
  output logic [7:0] bus_comm_o, // Bus register image
  output logic tx_disable_o // Transmitter disabled
);
  logic [1:0] pre_reg;
  logic cmdf_reg;
  logic fail_reg;
  logic [1:0] xf_reg;
  logic buv_reg;
  logic [1:0] wdc;
  logic uv_sync;
  logic wr_dev;
  logic wr_bus;
  logic freeze_cfg;
  logic one_fail_cfg;
  logic fail_evt;
  logic [7:0] dev_next;
  logic [7:0] bus_next;

  // Write decode
  assign wr_dev = wr_i.wr && (wr_i.addr == `DBS_DEV_ADDR);
  assign wr_bus = wr_i.wr && (wr_i.addr == `DBS_BUS_ADDR);
  // Configuration decode
  assign freeze_cfg = dev_cfg_i[0]; // Configurations 2 and 4
  assign one_fail_cfg = (dev_cfg_i == 2'h1);
  assign fail_evt = evt_i.watchdog_failure_count | evt_i.sev_ot | evt_i.main_uv |
                    evt_i.sleep_nowake | evt_i.failsafe_wake;

  dbs_sync3 u_uv_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(bus_uv_pin_i),
    .sync_o(uv_sync)
  );

  dbs_wd_count u_wdc (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .watchdog_failure_count_i(evt_i.watchdog_failure_count),
    .wd_ok_i(evt_i.wd_ok),
    .freeze_cfg_i(freeze_cfg),
    .one_fail_cfg_i(one_fail_cfg),
    .clr_i(wr_dev && (wr_i.data[`DBS_WDC_HI:`DBS_WDC_LO] != 2'h0)),
    .count_o(wdc),
    .frozen_o()
  );

  // Pre-restart state: failure beats sleep, set beats clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pre_reg <= DBS_PRE_CLEAR;
    end else if (fail_evt) begin
      pre_reg <= DBS_PRE_FAIL;
    end else if (evt_i.sleep_entry || evt_i.sleep_flags_set) begin
      pre_reg <= DBS_PRE_SLEEP;
    end else if (wr_dev && (wr_i.data[`DBS_PRE_HI:`DBS_PRE_LO] != 2'h0)) begin
      pre_reg <= DBS_PRE_CLEAR;
    end
  end

  // Invalid-command flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cmdf_reg <= 1'b0;
    end else if (evt_i.bad_cmd) begin
      cmdf_reg <= 1'b1;
    end else if (wr_dev && wr_i.data[`DBS_CMDF_BIT]) begin
      cmdf_reg <= 1'b0;
    end
  end

  // Fail output activation flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fail_reg <= 1'b0;
    end else if (evt_i.fail_out_on) begin
      fail_reg <= 1'b1;
    end else if (wr_dev && wr_i.data[`DBS_FAIL_BIT]) begin
      fail_reg <= 1'b0;
    end
  end

  // Transceiver failure cause, latest event wins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      xf_reg <= DBS_XF_NONE;
    end else if (evt_i.bus_dom) begin
      xf_reg <= DBS_XF_BUSDOM;
    end else if (evt_i.txd_dom) begin
      xf_reg <= DBS_XF_TXDOM;
    end else if (evt_i.xcv_therm) begin
      xf_reg <= DBS_XF_THERM;
    end else if (wr_bus && (wr_i.data[`DBS_XF_HI:`DBS_XF_LO] != 2'h0)) begin
      xf_reg <= DBS_XF_NONE;
    end
  end

  // Bus supply undervoltage, gated by transceiver mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      buv_reg <= 1'b0;
    end else if (uv_sync && xcv_mode_i) begin
      buv_reg <= 1'b1;
    end else if (wr_bus && wr_i.data[`DBS_BUV_BIT]) begin
      buv_reg <= 1'b0;
    end
  end

  // Register images with reserved bits zero
  always_comb begin
    dev_next = `DBS_DEV_RST;
    dev_next[`DBS_PRE_HI:`DBS_PRE_LO] = pre_reg;
    dev_next[`DBS_WDC_HI:`DBS_WDC_LO] = wdc;
    dev_next[`DBS_CMDF_BIT] = cmdf_reg;
    dev_next[`DBS_FAIL_BIT] = fail_reg;
    bus_next = `DBS_BUS_RST;
    bus_next[`DBS_XF_HI:`DBS_XF_LO] = xf_reg;
    bus_next[`DBS_BUV_BIT] = buv_reg;
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dev_info_o <= `DBS_DEV_RST;
      bus_comm_o <= `DBS_BUS_RST;
      tx_disable_o <= 1'b0;
    end else begin
      dev_info_o <= dev_next;
      bus_comm_o <= bus_next;
      tx_disable_o <= buv_reg;
    end
  end

  // Read port, one cycle latency, no side effect
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      if (rd_addr_i == `DBS_DEV_ADDR) begin
        rd_data_o <= dev_next;
      end else if (rd_addr_i == `DBS_BUS_ADDR) begin
        rd_data_o <= bus_next;
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // Pre-restart state checks
  a_pre_fail_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fail_evt |=> pre_reg == DBS_PRE_FAIL) else $error("failure code missing");
  a_pre_no_self: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pre_reg != 2'h0 && !wr_dev |=> pre_reg != 2'h0) else $error("state self cleared");
  a_pre_sleep: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (evt_i.sleep_entry || evt_i.sleep_flags_set) && !fail_evt |=> pre_reg == DBS_PRE_SLEEP)
    else $error("sleep code missing");
  // Flag and image checks
  a_cmd_flag_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    evt_i.bad_cmd |=> ##1 dev_info_o[1]) else $error("command flag not shown");
  a_cmd_flag_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmdf_reg && !wr_dev |=> cmdf_reg) else $error("command flag lost");
  a_fail_flag_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    evt_i.fail_out_on |=> fail_reg) else $error("fail flag not set");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    dev_info_o[5:4] == 2'h0 && bus_comm_o[7:3] == 5'h00)
    else $error("reserved bit set");
  a_reset_zero: assert property (@(posedge clk_i)
    !nrst_i |=> dev_info_o == 8'h00 && bus_comm_o == 8'h00)
    else $error("reset value wrong");
  // Bus register checks
  a_uv_gated: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !buv_reg && !xcv_mode_i |=> !buv_reg) else $error("undervoltage with mode off");
  a_uv_txoff: assert property (@(posedge clk_i) disable iff (!nrst_i)
    buv_reg |=> tx_disable_o) else $error("transmitter not disabled");
  a_xf_code: assert property (@(posedge clk_i) disable iff (!nrst_i)
    evt_i.txd_dom && !evt_i.bus_dom |=> xf_reg == DBS_XF_TXDOM)
    else $error("transmit timeout code wrong");
  // Main scenarios
  c_fail_restart: cover property (@(posedge clk_i) disable iff (!nrst_i) fail_evt);
  c_sleep_flags: cover property (@(posedge clk_i) disable iff (!nrst_i)
    evt_i.sleep_flags_set && !evt_i.sleep_entry);
  c_wd_two: cover property (@(posedge clk_i) disable iff (!nrst_i) wdc == 2'h2);
  c_uv_set: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(buv_reg));
endmodule : dbs_status_regs

// ==== sim/dbs_host_model.sv ====
/*
 Host model: issues register reads and writes to the status bank.
 Assumes the bank takes requests on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module dbs_host_model
  import dbs_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic [7:0] rd_data_i, // Read data from the bank
  output dbs_wr_t wr_o, // Write strobe bundle
  output logic rd_o, // Read strobe
  output logic [6:0] rd_addr_o // Read address
);
  // Idle bus at time zero
  initial begin
    wr_o = '0;
    rd_o = 1'b0;
    rd_addr_o = 7'h00;
  end
  // One-cycle write, then lines left scrambled
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o = '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_i);
    #1;
    wr_o = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask : wr_reg
  // One-cycle read, data taken after the read edge
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_o = 1'b1;
    rd_addr_o = a;
    @(posedge clk_i);
    #1;
    d = rd_data_i;
    rd_o = 1'b0;
    rd_addr_o = ~a;
  endtask : rd_reg
endmodule : dbs_host_model

// ==== sim/tb.sv ====
/*
 Self-checking bench for the device and bus status bank.
 Assumes the host model in dbs_host_model.sv drives the register port.
*/
`timescale 1ns/1ps
module tb
  import dbs_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  dbs_evt_t evt_i = '0;
  dbs_wr_t wr_i;
  logic rd_i;
  logic [6:0] rd_addr_i;
  logic [1:0] dev_cfg_i = 2'h0;
  logic xcv_mode_i = 1'b0;
  logic bus_uv_pin_i = 1'b0;
  logic [7:0] rd_data_o;
  logic [7:0] dev_info_o;
  logic [7:0] bus_comm_o;
  logic tx_disable_o;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // 50 ns clock
  always #25 clk_i = ~clk_i;
  dbs_status_regs dbs_status_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i), .evt_i(evt_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_addr_i(rd_addr_i), .dev_cfg_i(dev_cfg_i),
    .xcv_mode_i(xcv_mode_i), .bus_uv_pin_i(bus_uv_pin_i), .rd_data_o(rd_data_o),
    .dev_info_o(dev_info_o), .bus_comm_o(bus_comm_o), .tx_disable_o(tx_disable_o));
  dbs_host_model dbs_host_model_inst (.clk_i(clk_i), .rd_data_i(rd_data_o), .wr_o(wr_i),
    .rd_o(rd_i), .rd_addr_o(rd_addr_i));
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Read a register and compare the masked value
  task automatic rdchk(input string n, input logic [6:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] d;
    dbs_host_model_inst.rd_reg(a, d);
    chk(n, d & m, e);
  endtask : rdchk
  // One-cycle event pulse
  task automatic pulse(input logic [12:0] v);
    @(posedge clk_i);
    #1;
    evt_i = v;
    @(posedge clk_i);
    #1;
    evt_i = '0;
  endtask : pulse
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc
  // Main sequence
  initial begin
    wait_cyc(10);
    nrst_i = 1'b1;
    rdchk("dev_rst", 7'h43, 8'hff, 8'h00);
    rdchk("bus_rst", 7'h44, 8'hff, 8'h00);
    $display("test reset done");
    pulse(13'h0010);
    rdchk("cmd_flag", 7'h43, 8'hff, 8'h02);
    rdchk("cmd_sticky", 7'h43, 8'hff, 8'h02);
    dbs_host_model_inst.wr_reg(7'h43, 8'h02);
    rdchk("cmd_clr", 7'h43, 8'hff, 8'h00);
    pulse(13'h0008);
    rdchk("fail_flag", 7'h43, 8'hff, 8'h01);
    dbs_host_model_inst.wr_reg(7'h43, 8'h01);
    $display("test flags done");
    for (int i = 7; i < 11; i++) begin
      pulse(13'h1 << i);
      rdchk("pre_fail", 7'h43, 8'hff, 8'h40);
      dbs_host_model_inst.wr_reg(7'h43, 8'hc0);
    end
    pulse(13'h0040);
    rdchk("pre_sleep", 7'h43, 8'hff, 8'h80);
    dbs_host_model_inst.wr_reg(7'h43, 8'hc0);
    pulse(13'h0020);
    rdchk("pre_sleep_flags", 7'h43, 8'hff, 8'h80);
    wait_cyc(20);
    rdchk("pre_hold", 7'h43, 8'hff, 8'h80);
    dbs_host_model_inst.wr_reg(7'h43, 8'hc0);
    pulse(13'h0440);
    rdchk("pre_prio", 7'h43, 8'hff, 8'h40);
    pulse(13'h0018);
    rdchk("dev_all", 7'h43, 8'hff, 8'h43);
    chk("dev_image", dev_info_o, 8'h43);
    dbs_host_model_inst.wr_reg(7'h43, 8'hcf);
    $display("test pre-restart done");
    for (int i = 0; i < 3; i++) begin
      pulse(13'h1000);
      rdchk("wd_cnt", 7'h43, 8'h0c, (i == 0) ? 8'h04 : 8'h08);
    end
    pulse(13'h0800);
    rdchk("wd_auto", 7'h43, 8'h0c, 8'h00);
    dbs_host_model_inst.wr_reg(7'h43, 8'hcf);
    for (int c = 1; c < 4; c += 2) begin
      dev_cfg_i = c[1:0];
      repeat ((c == 1) ? 2 : 1) pulse(13'h1000);
      rdchk("wd_frz", 7'h43, 8'h0c, 8'h04);
      pulse(13'h0800);
      rdchk("wd_held", 7'h43, 8'h0c, 8'h04);
      if (c == 1) begin
        pulse(13'h1000);
        rdchk("wd_sat_one", 7'h43, 8'h0c, 8'h04);
        pulse(13'h0800);
      end
      pulse(13'h0800);
      rdchk("wd_rel", 7'h43, 8'h0c, 8'h00);
      dbs_host_model_inst.wr_reg(7'h43, 8'hcf);
    end
    dev_cfg_i = 2'h2;
    repeat (2) pulse(13'h1000);
    rdchk("wd_cfg3", 7'h43, 8'h0c, 8'h08);
    pulse(13'h0800);
    rdchk("wd_cfg3_clr", 7'h43, 8'h0c, 8'h00);
    dev_cfg_i = 2'h0;
    dbs_host_model_inst.wr_reg(7'h43, 8'hcf);
    $display("test watchdog done");
    for (int i = 0; i < 3; i++) begin
      pulse(13'h1 << (2 - i));
      rdchk("xcv_code", 7'h44, 8'hff, 8'(2 * (i + 1)));
      dbs_host_model_inst.wr_reg(7'h44, 8'h06);
    end
    bus_uv_pin_i = 1'b1;
    wait_cyc(8);
    rdchk("uv_off", 7'h44, 8'hff, 8'h00);
    xcv_mode_i = 1'b1;
    wait_cyc(8);
    rdchk("uv_on", 7'h44, 8'hff, 8'h01);
    chk("tx_dis", {7'h00, tx_disable_o}, 8'h01);
    chk("bus_image", bus_comm_o, 8'h01);
    dbs_host_model_inst.wr_reg(7'h44, 8'h01);
    rdchk("uv_set_wins", 7'h44, 8'hff, 8'h01);
    bus_uv_pin_i = 1'b0;
    wait_cyc(8);
    rdchk("uv_sticky", 7'h44, 8'hff, 8'h01);
    dbs_host_model_inst.wr_reg(7'h44, 8'h01);
    wait_cyc(2);
    rdchk("uv_clr", 7'h44, 8'hff, 8'h00);
    chk("tx_en", {7'h00, tx_disable_o}, 8'h00);
    xcv_mode_i = 1'b0;
    $display("test bus done");
    pulse(13'h0014);
    dbs_host_model_inst.wr_reg(7'h45, 8'hff);
    rdchk("unmapped", 7'h45, 8'hff, 8'h00);
    rdchk("wr_ignored", 7'h43, 8'hff, 8'h02);
    nrst_i = 1'b0;
    wait_cyc(2);
    nrst_i = 1'b1;
    rdchk("dev_soft", 7'h43, 8'hff, 8'h00);
    rdchk("bus_soft", 7'h44, 8'hff, 8'h00);
    chk("dev_image_soft", dev_info_o, 8'h00);
    chk("bus_image_soft", bus_comm_o, 8'h00);
    chk("tx_soft", {7'h00, tx_disable_o}, 8'h00);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule : tb
